// *** core/dpg_pkg.sv ***
// Package for the dual port GPIO block: register map, field positions, reset values.
// Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
package dpg_pkg;
    localparam int NARROW_W = 6;
    localparam int WIDE_W = 8;
    localparam int ADDR_W = 5;
    // Byte offsets of the registers
    localparam logic [4:0] OFS_NARROW_DATA = 5'h00;
    localparam logic [4:0] OFS_NARROW_DIR = 5'h04;
    localparam logic [4:0] OFS_NARROW_PUE = 5'h08;
    localparam logic [4:0] OFS_WIDE_DATA = 5'h0C;
    localparam logic [4:0] OFS_WIDE_DIR = 5'h10;
    localparam logic [4:0] OFS_WIDE_PUE = 5'h14;
    // Field positions
    localparam int BIT_INPUT_ONLY = 2;
    localparam int BIT_CLKOUT_PIN = 4;
    localparam int BIT_WAKEUP = 6;
    localparam int BIT_CLKOUT_EN = 7;
    // Oscillator option codes
    localparam logic [1:0] OSC_INTERNAL = 2'h0;
    localparam logic [1:0] OSC_EXT_CLOCK = 2'h1;
    localparam logic [1:0] OSC_EXT_RC = 2'h2;
    localparam logic [1:0] OSC_CRYSTAL = 2'h3;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] PUE_RESET = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } dpg_req_t;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] pue;
        logic [7:0] latch;
    } dpg_port_cfg_t;
endpackage : dpg_pkg

// *** core/dpg_pin_slice.sv ***
// One GPIO pin: output enable, pullup gating and read-back select.
// Assumes pin input is already synchronised by the caller.
`timescale 1ns/10ps
`default_nettype none
module dpg_pin_slice #(
    parameter bit CAN_DRIVE = 1'b1
) (
    input wire logic dir,
    input wire logic pue,
    input wire logic latch,
    input wire logic pin_sync,
    output logic drive_oe_n,
    output logic pullup_on,
    output logic read_val
);
    wire logic driving;

    // Input-only pin never gets a driver
    assign driving = dir & CAN_DRIVE;
    assign drive_oe_n = ~driving;
    assign pullup_on = pue & ~dir;
    assign read_val = dir ? latch : pin_sync;
endmodule : dpg_pin_slice
`default_nettype wire

// *** core/dpg_gpio.sv ***
// Dual GPIO port (6-bit narrow, 8-bit wide) with pullups and clock-out option.
// Assumes an Avalon-MM master on CLK_SYS; pins come from pads and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
module dpg_gpio #(
    parameter int NW = dpg_pkg::NARROW_W,
    parameter int WW = dpg_pkg::WIDE_W
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [dpg_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [1:0] OSC_OPTION,
    input wire logic EXT_IRQ_ENABLE,
    input wire logic WAKEUP_REQUEST_LATCH,
    input wire logic QUADRUPLED_BUS_CLOCK,
    input wire logic [NW-1:0] NARROW_PIN_IN,
    output logic [NW-1:0] NARROW_PIN_OUT,
    output logic [NW-1:0] NARROW_PIN_OE_N,
    output logic [NW-1:0] NARROW_PULLUP,
    input wire logic [WW-1:0] WIDE_PIN_IN,
    output logic [WW-1:0] WIDE_PIN_OUT,
    output logic [WW-1:0] WIDE_PIN_OE_N,
    output logic [WW-1:0] WIDE_PULLUP,
    output logic CLOCK_OUTPUT_ACTIVE
);
    dpg_pkg::dpg_req_t req;
    logic [NW-1:0] narrow_meta;
    logic [NW-1:0] narrow_sync;
    logic [WW-1:0] wide_meta;
    logic [WW-1:0] wide_sync;
    logic wake_meta;
    logic wake_sync;
    logic irq_meta;
    logic irq_sync;
    logic answered;
    logic [NW-1:0] narrow_dir;
    logic [NW-1:0] narrow_pue;
    logic [NW-1:0] narrow_latch;
    logic clock_output_enable;
    logic [WW-1:0] wide_dir;
    logic [WW-1:0] wide_pue;
    logic [WW-1:0] wide_latch;
    logic [31:0] readdata;
    wire logic [NW-1:0] narrow_read_bits;
    wire logic [WW-1:0] wide_read_bits;
    wire logic [NW-1:0] narrow_oe_n_raw;
    wire logic [WW-1:0] wide_oe_n_raw;
    wire logic [NW-1:0] narrow_pull_raw;
    wire logic access;
    wire logic wr_lane0;
    wire logic wr_lane1;
    wire logic sel_ndata;
    wire logic sel_ndir;
    wire logic sel_npue;
    wire logic sel_wdata;
    wire logic sel_wdir;
    wire logic sel_wpue;
    wire logic osc_allows_clkout;
    wire logic clkout_active;
    wire logic [7:0] narrow_data_word;
    wire logic [31:0] next_readdata;

    assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                   writedata: AVS_WRITEDATA, byteenable: AVS_BYTEENABLE};

    // Two-stage synchronisers for pins and outside levels
    // Pads change at any time: only the second stage feeds logic
    always_ff @(posedge CLK_SYS) begin
        narrow_meta <= NARROW_PIN_IN;
        narrow_sync <= narrow_meta;
        wide_meta <= WIDE_PIN_IN;
        wide_sync <= wide_meta;
        wake_meta <= WAKEUP_REQUEST_LATCH;
        wake_sync <= wake_meta;
        irq_meta <= EXT_IRQ_ENABLE;
        irq_sync <= irq_meta;
    end

    // One wait cycle per access: answer on the second edge
    // Costs a cycle per access but read data come straight from a flop
    assign access = (req.read | req.write) & ~answered;
    assign AVS_WAITREQUEST = (req.read | req.write) & ~answered;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            answered <= 1'b0;
        end else begin
            answered <= access;
        end
    end

    // Write takes effect on the edge where waitrequest is low
    wire logic commit = req.write & answered;
    assign wr_lane0 = commit & req.byteenable[0];
    assign wr_lane1 = commit & req.byteenable[0];
    assign sel_ndata = req.address == dpg_pkg::OFS_NARROW_DATA;
    assign sel_ndir = req.address == dpg_pkg::OFS_NARROW_DIR;
    assign sel_npue = req.address == dpg_pkg::OFS_NARROW_PUE;
    assign sel_wdata = req.address == dpg_pkg::OFS_WIDE_DATA;
    assign sel_wdir = req.address == dpg_pkg::OFS_WIDE_DIR;
    assign sel_wpue = req.address == dpg_pkg::OFS_WIDE_PUE;

    // Latches have no reset: contents survive a system reset
    always_ff @(posedge CLK_SYS) begin
        if (wr_lane0 && sel_ndata) begin
            narrow_latch <= req.writedata[NW-1:0];
        end
        if (wr_lane1 && sel_wdata) begin
            wide_latch <= req.writedata[WW-1:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            narrow_dir <= dpg_pkg::DIR_RESET[NW-1:0];
            wide_dir <= dpg_pkg::DIR_RESET[WW-1:0];
            narrow_pue <= dpg_pkg::PUE_RESET[NW-1:0];
            wide_pue <= dpg_pkg::PUE_RESET[WW-1:0];
            clock_output_enable <= 1'b0;
        end else begin
            if (wr_lane0 && sel_ndir) begin
                narrow_dir <= req.writedata[NW-1:0];
            end
            if (wr_lane0 && sel_npue) begin
                narrow_pue <= req.writedata[NW-1:0];
                clock_output_enable <= req.writedata[dpg_pkg::BIT_CLKOUT_EN];
            end
            if (wr_lane0 && sel_wdir) begin
                wide_dir <= req.writedata[WW-1:0];
            end
            if (wr_lane0 && sel_wpue) begin
                wide_pue <= req.writedata[WW-1:0];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NW; gi++) begin : g_narrow
            dpg_pin_slice #(.CAN_DRIVE(gi != dpg_pkg::BIT_INPUT_ONLY)) u_pin (
                .dir(narrow_dir[gi]),
                .pue(narrow_pue[gi]),
                .latch(narrow_latch[gi]),
                .pin_sync(narrow_sync[gi]),
                .drive_oe_n(narrow_oe_n_raw[gi]),
                .pullup_on(narrow_pull_raw[gi]),
                .read_val(narrow_read_bits[gi])
            );
        end
        for (gi = 0; gi < WW; gi++) begin : g_wide
            dpg_pin_slice #(.CAN_DRIVE(1'b1)) u_pin (
                .dir(wide_dir[gi]),
                .pue(wide_pue[gi]),
                .latch(wide_latch[gi]),
                .pin_sync(wide_sync[gi]),
                .drive_oe_n(wide_oe_n_raw[gi]),
                .pullup_on(WIDE_PULLUP[gi]),
                .read_val(wide_read_bits[gi])
            );
        end
    endgenerate

    // Clock-out only honoured for internal or RC oscillator
    assign osc_allows_clkout = (OSC_OPTION == dpg_pkg::OSC_INTERNAL)
                               || (OSC_OPTION == dpg_pkg::OSC_EXT_RC);
    assign clkout_active = clock_output_enable & osc_allows_clkout;
    assign CLOCK_OUTPUT_ACTIVE = clkout_active;

    always_comb begin
        NARROW_PIN_OUT = narrow_latch;
        NARROW_PIN_OE_N = narrow_oe_n_raw;
        NARROW_PULLUP = narrow_pull_raw;
        if (clkout_active) begin
            // Pin given over to the clock: driven, pullup off
            NARROW_PIN_OUT[dpg_pkg::BIT_CLKOUT_PIN] = QUADRUPLED_BUS_CLOCK;
            NARROW_PIN_OE_N[dpg_pkg::BIT_CLKOUT_PIN] = 1'b0;
            NARROW_PULLUP[dpg_pkg::BIT_CLKOUT_PIN] = 1'b0;
        end
    end
    assign WIDE_PIN_OUT = wide_latch;
    assign WIDE_PIN_OE_N = wide_oe_n_raw;

    // Narrow data word: bit 2 masked by interrupt, bit 6 from wakeup latch
    assign narrow_data_word = {1'b0, wake_sync,
                               narrow_read_bits[5:3],
                               narrow_read_bits[2] & ~irq_sync,
                               narrow_read_bits[1:0]};

    assign next_readdata =
        sel_ndata ? {24'h000000, narrow_data_word} :
        sel_ndir ? {26'h0000000, narrow_dir} :
        sel_npue ? {24'h000000, clock_output_enable, 1'b0, narrow_pue} :
        sel_wdata ? {24'h000000, wide_read_bits} :
        sel_wdir ? {24'h000000, wide_dir} :
        sel_wpue ? {24'h000000, wide_pue} :
        dpg_pkg::UNMAPPED_READ;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            readdata <= dpg_pkg::UNMAPPED_READ;
        end else if (access) begin
            readdata <= next_readdata;
        end
    end
    assign AVS_READDATA = readdata;

    // Assertions
    a_dir_reset_clear: assert property (@(posedge CLK_SYS)
        RST |=> (narrow_dir == '0 && wide_dir == '0))
        else $error("direction not cleared by reset");
    a_pue_reset_clear: assert property (@(posedge CLK_SYS)
        RST |=> (narrow_pue == '0 && wide_pue == '0 && !clock_output_enable))
        else $error("pullup enables not cleared by reset");
    a_bit2_never_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
        NARROW_PIN_OE_N[dpg_pkg::BIT_INPUT_ONLY])
        else $error("input-only pin driven");
    a_wide_pull_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
        (WIDE_PULLUP == (wide_pue & ~wide_dir)))
        else $error("wide pullup wrong");
    a_narrow_pull_off: assert property (@(posedge CLK_SYS) disable iff (RST)
        ((NARROW_PULLUP & ~narrow_pue) == '0 && (NARROW_PULLUP & narrow_dir) == '0))
        else $error("narrow pullup wrong");
    a_narrow_pull_on: assert property (@(posedge CLK_SYS) disable iff (RST)
        !clkout_active |-> (NARROW_PULLUP == (narrow_pue & ~narrow_dir)))
        else $error("narrow pullup missing");
    a_wide_oe_dir: assert property (@(posedge CLK_SYS) disable iff (RST)
        (WIDE_PIN_OE_N == ~wide_dir))
        else $error("wide output enable wrong");
    a_narrow_oe_dir: assert property (@(posedge CLK_SYS) disable iff (RST)
        !clkout_active |-> (NARROW_PIN_OE_N == ~(narrow_dir & ~(NW'(1) << dpg_pkg::BIT_INPUT_ONLY))))
        else $error("narrow output enable wrong");
    a_clkout_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
        (OSC_OPTION == dpg_pkg::OSC_CRYSTAL || OSC_OPTION == dpg_pkg::OSC_EXT_CLOCK)
        |-> !CLOCK_OUTPUT_ACTIVE)
        else $error("clock out in wrong mode");
    a_clkout_on: assert property (@(posedge CLK_SYS) disable iff (RST)
        (clock_output_enable && (OSC_OPTION == dpg_pkg::OSC_INTERNAL || OSC_OPTION == dpg_pkg::OSC_EXT_RC))
        |-> CLOCK_OUTPUT_ACTIVE)
        else $error("clock out not enabled");
    a_clkout_route: assert property (@(posedge CLK_SYS) disable iff (RST)
        CLOCK_OUTPUT_ACTIVE |-> (NARROW_PIN_OUT[dpg_pkg::BIT_CLKOUT_PIN] == QUADRUPLED_BUS_CLOCK
            && !NARROW_PIN_OE_N[dpg_pkg::BIT_CLKOUT_PIN] && !NARROW_PULLUP[dpg_pkg::BIT_CLKOUT_PIN]))
        else $error("clock not routed to pin");
    sequence s_wide_write;
        AVS_WRITE && !AVS_WAITREQUEST && sel_wdata && AVS_BYTEENABLE[0];
    endsequence
    sequence s_narrow_write;
        AVS_WRITE && !AVS_WAITREQUEST && sel_ndata && AVS_BYTEENABLE[0];
    endsequence
    sequence s_narrow_read;
        AVS_READ && AVS_WAITREQUEST && sel_ndata;
    endsequence
    a_wide_latch_write: assert property (@(posedge CLK_SYS)
        s_wide_write |=> (wide_latch == $past(AVS_WRITEDATA[WW-1:0])))
        else $error("wide latch not written");
    a_narrow_latch_write: assert property (@(posedge CLK_SYS)
        s_narrow_write |=> (narrow_latch == $past(AVS_WRITEDATA[NW-1:0])))
        else $error("narrow latch not written");
    a_wait_one_cycle: assert property (@(posedge CLK_SYS) disable iff (RST)
        ($rose(AVS_READ) && !answered) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("waitrequest timing wrong");
    a_write_wait: assert property (@(posedge CLK_SYS) disable iff (RST)
        ($rose(AVS_WRITE) && !answered) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("write waitrequest timing wrong");
    a_wide_read_sel: assert property (@(posedge CLK_SYS) disable iff (RST)
        (AVS_READ && AVS_WAITREQUEST && sel_wdata) |=>
            (((AVS_READDATA[WW-1:0] ^ $past(wide_latch)) & $past(wide_dir)) == '0
            && ((AVS_READDATA[WW-1:0] ^ $past(wide_sync)) & ~$past(wide_dir)) == '0))
        else $error("wide read data wrong");
    a_narrow_read_sel: assert property (@(posedge CLK_SYS) disable iff (RST)
        s_narrow_read |=> (AVS_READDATA[dpg_pkg::BIT_WAKEUP] == $past(wake_sync)
            && !($past(irq_sync) && AVS_READDATA[dpg_pkg::BIT_INPUT_ONLY])
            && ((AVS_READDATA[NW-1:0] ^ $past(narrow_latch)) & $past(narrow_dir)
                & ~(NW'(1) << dpg_pkg::BIT_INPUT_ONLY)) == '0))
        else $error("narrow read data wrong");
    a_narrow_dir_read: assert property (@(posedge CLK_SYS) disable iff (RST)
        (AVS_READ && AVS_WAITREQUEST && sel_ndir) |=> (AVS_READDATA[31:NW] == '0))
        else $error("unused direction bits not zero");
    a_unmapped_read: assert property (@(posedge CLK_SYS) disable iff (RST)
        (AVS_READ && AVS_WAITREQUEST && !(sel_ndata || sel_ndir || sel_npue || sel_wdata || sel_wdir || sel_wpue))
        |=> (AVS_READDATA == dpg_pkg::UNMAPPED_READ))
        else $error("unmapped read not zero");
endmodule : dpg_gpio
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the dual port GPIO block: register access, pins, pullups, clock out.
// Assumes one wait cycle per Avalon access and two-flop input synchronisers in the design.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h00000000;
    logic [3:0] be = 4'hF;
    logic [31:0] rdat;
    logic wait_req;
    logic [1:0] osc = 2'h3;
    logic irq_en = 1'b0;
    logic wake = 1'b0;
    logic qclk = 1'b0;
    logic [5:0] n_in = 6'h00;
    logic [5:0] n_out;
    logic [5:0] n_oe_n;
    logic [5:0] n_pu;
    logic [7:0] w_in = 8'h00;
    logic [7:0] w_out;
    logic [7:0] w_oe_n;
    logic [7:0] w_pu;
    logic clk_act;
    logic [31:0] q;
    logic e;
    int fail_count = 0;
    int n_tests = 0;

    always #50 clk_sys = ~clk_sys;

    dpg_gpio uut (.CLK_SYS(clk_sys), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
        .OSC_OPTION(osc), .EXT_IRQ_ENABLE(irq_en), .WAKEUP_REQUEST_LATCH(wake), .QUADRUPLED_BUS_CLOCK(qclk),
        .NARROW_PIN_IN(n_in), .NARROW_PIN_OUT(n_out), .NARROW_PIN_OE_N(n_oe_n), .NARROW_PULLUP(n_pu),
        .WIDE_PIN_IN(w_in), .WIDE_PIN_OUT(w_out), .WIDE_PIN_OE_N(w_oe_n), .WIDE_PULLUP(w_pu),
        .CLOCK_OUTPUT_ACTIVE(clk_act));

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request held until waitrequest is sampled low; one idle edge after each access
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        adr <= a;
        wdat <= d;
        rd <= ~w;
        wr <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (wait_req === 1'b0) break;
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 20) begin
            fail_count++;
            tally_and_finish();
        end
        @(posedge clk_sys);
    endtask : bus

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h000000, d});
    endtask : wr_reg

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(q, {24'h000000, exp});
    endtask : rd_chk

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd_chk(dpg_pkg::OFS_NARROW_DIR, 8'h00);
        rd_chk(dpg_pkg::OFS_WIDE_DIR, 8'h00);
        chk(32'(w_pu), 32'h00);
        // Wide port: latch loaded while pins are inputs
        w_in <= 8'h3C;
        wr_reg(dpg_pkg::OFS_WIDE_DATA, 8'hA5);
        chk(32'(w_out), 32'hA5);
        rd_chk(dpg_pkg::OFS_WIDE_DATA, 8'h3C);
        wr_reg(dpg_pkg::OFS_WIDE_DIR, 8'h0F);
        chk(32'(w_oe_n), 32'hF0);
        rd_chk(dpg_pkg::OFS_WIDE_DATA, 8'h35);
        wr_reg(dpg_pkg::OFS_WIDE_PUE, 8'hFF);
        chk(32'(w_pu), 32'hF0);
        wr_reg(dpg_pkg::OFS_WIDE_PUE, 8'h00);
        chk(32'(w_pu), 32'h00);
        // Write without lane 0 and a read of an unmapped place are both refused
        be <= 4'h0;
        wr_reg(dpg_pkg::OFS_WIDE_DATA, 8'hFF);
        be <= 4'hF;
        chk(32'(w_out), 32'hA5);
        rd_chk(5'h18, 8'h00);
        // Narrow port
        n_in <= 6'h2E;
        wake <= 1'b1;
        wr_reg(dpg_pkg::OFS_NARROW_DATA, 8'h15);
        wr_reg(dpg_pkg::OFS_NARROW_DIR, 8'hFF);
        rd_chk(dpg_pkg::OFS_NARROW_DIR, 8'h3F);
        chk(32'(n_oe_n), 32'h04);
        rd_chk(dpg_pkg::OFS_NARROW_DATA, 8'h55);
        wr_reg(dpg_pkg::OFS_NARROW_DIR, 8'h03);
        chk(32'(n_oe_n), 32'h3C);
        rd_chk(dpg_pkg::OFS_NARROW_DATA, 8'h6D);
        irq_en <= 1'b1;
        wake <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd_chk(dpg_pkg::OFS_NARROW_DATA, 8'h29);
        wr_reg(dpg_pkg::OFS_NARROW_PUE, 8'h3F);
        chk(32'(n_pu), 32'h3C);
        // Clock out only for internal and RC options; latch bit four is 1, clock held at 0
        for (int k = 0; k < 4; k++) begin
            osc <= k[1:0];
            wr_reg(dpg_pkg::OFS_NARROW_PUE, 8'h80);
            e = (k == 0 || k == 2);
            chk(32'(clk_act), 32'(e));
            chk(32'(n_out[4]), 32'(!e));
            chk(32'(n_pu), 32'h00);
        end
        // Routed pin follows the fast clock and is driven although its direction is input
        osc <= dpg_pkg::OSC_EXT_RC;
        qclk <= 1'b1;
        @(posedge clk_sys);
        chk(32'(n_out[4]), 32'h1);
        chk(32'(n_oe_n[4]), 32'h0);
        qclk <= 1'b0;
        osc <= dpg_pkg::OSC_CRYSTAL;
        @(posedge clk_sys);
        chk(32'(n_oe_n[4]), 32'h1);
        // Second reset: latches survive, directions clear
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk(32'(w_out), 32'hA5);
        chk(32'(n_out), 32'h15);
        chk(32'(w_oe_n), 32'hFF);
        rd_chk(dpg_pkg::OFS_NARROW_DIR, 8'h00);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
